// ---- verilog/vca_pkg.sv ----
package vca_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses, one aligned 32-bit word each)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_ID        = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_FRAME_CNT = 8'h08;
  localparam logic [7:0] ADDR_LINK_BASE = 8'h10;
  localparam int         LINK_STRIDE_LG = 2;

  // Identity word, value is arbitrary
  localparam logic [31:0] BLOCK_ID      = 32'h0000_5a01;

  // ------------------------------------------------------------------
  // Link configuration word fields
  // ------------------------------------------------------------------
  localparam int SCHEME_LSB = 0;
  localparam int SCHEME_W   = 2;
  localparam int COUNT_LSB  = 16;
  localparam int COUNT_W    = 9;
  localparam int CFG_W      = SCHEME_W + COUNT_W;

  typedef enum logic [SCHEME_W-1:0] {
    VCA_SCHEME_SIMPLE   = 2'h0,
    VCA_SCHEME_FIXED    = 2'h1,
    VCA_SCHEME_VARIABLE = 2'h2,
    VCA_SCHEME_UNUSED   = 2'h3
  } vca_scheme_type;

  // Reset configuration: simple scheme on two channels
  localparam logic [COUNT_W-1:0]  CFG_RST_COUNT  = 9'h002;
  localparam logic [SCHEME_W-1:0] CFG_RST_SCHEME = 2'h0;

  // ------------------------------------------------------------------
  // Channel numbers and accepted channel counts
  // ------------------------------------------------------------------
  localparam int          VC_W       = 8;
  localparam logic [7:0]  VC_CTRL    = 8'h00;
  localparam logic [7:0]  VC_DATA    = 8'h01;
  localparam logic [7:0]  VC_FIX_LOW = 8'h02;
  localparam logic [7:0]  VC_FULL    = 8'hff;
  localparam logic [8:0]  CNT_ONE    = 9'h001;
  localparam logic [8:0]  CNT_SIMPLE = 9'h002;

  localparam logic [8:0]  FIX_N0 = 9'h008;
  localparam logic [8:0]  FIX_N1 = 9'h00c;
  localparam logic [8:0]  FIX_N2 = 9'h014;
  localparam logic [8:0]  FIX_N3 = 9'h024;
  localparam logic [8:0]  FIX_N4 = 9'h044;
  localparam logic [8:0]  FIX_N5 = 9'h084;

  localparam logic [8:0]  VAR_N0 = 9'h004;
  localparam logic [8:0]  VAR_N1 = 9'h008;
  localparam logic [8:0]  VAR_N2 = 9'h010;
  localparam logic [8:0]  VAR_N3 = 9'h020;
  localparam logic [8:0]  VAR_N4 = 9'h040;
  localparam logic [8:0]  VAR_N5 = 9'h080;
  localparam logic [8:0]  VAR_N6 = 9'h100;

  // Destination field: starts at bit 8, width 2..8 bits
  localparam int          DID_W     = 24;
  localparam int          DID_FIELD = 8;
  localparam logic [3:0]  FW_NONE   = 4'h0;
  localparam logic [3:0]  FW_2      = 4'h2;
  localparam logic [3:0]  FW_3      = 4'h3;
  localparam logic [3:0]  FW_4      = 4'h4;
  localparam logic [3:0]  FW_5      = 4'h5;
  localparam logic [3:0]  FW_6      = 4'h6;
  localparam logic [3:0]  FW_7      = 4'h7;
  localparam logic [3:0]  FW_8      = 4'h8;

endpackage

// ---- verilog/vca_assigner.sv ----
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Channel chosen from the link's agreed scheme and channel count.
// - Scheme and count are held separately for every link.
// - Simple scheme puts fabric-control frames on channel 0.
// - Simple scheme puts every other frame on channel 1.
// - Fixed scheme puts fabric-control frames on channel 0.
// - Fixed scheme puts non-control broadcast frames on channel count minus one.
// - Fixed scheme never uses channel 1 nor channel count minus two.
// - Fixed scheme routes other frames to channels 2 to count minus three.
// - Fixed counts 8..132 select destination bits 9:8 up to 14:8.
// - Fixed scheme is supported for eight or more channels.
// - Variable scheme routes control and broadcast frames by destination too.
// - Variable scheme sends control and broadcast frames first on a channel.
// - Variable counts 4..256 select destination bits 9:8 up to 15:8.
// - Variable scheme is supported for four or more channels.

// --------------------------------------------------------------------
// Synchronous FIFO
// --------------------------------------------------------------------
module vca_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [WIDTH-1:0]      rd_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 cnt;
  } vca_fifo_state_type;

  vca_fifo_state_type st_reg;
  vca_fifo_state_type st_next;
  logic               do_wr;
  logic               do_rd;

  // Flags come from the count, so full and empty never lie
  assign wr_ready_out = (st_reg.cnt != (AW+1)'(DEPTH));
  assign rd_valid_out = (st_reg.cnt != '0);
  assign rd_data_out  = st_reg.mem[st_reg.rptr];
  assign do_wr        = wr_valid_in && wr_ready_out;
  assign do_rd        = rd_valid_out && rd_ready_in;

  // Pointer and count update
  always_comb begin
    st_next = st_reg;
    if (do_wr) begin
      st_next.mem[st_reg.wptr] = wr_data_in;
      st_next.wptr = (st_reg.wptr == AW'(DEPTH-1)) ? '0 : st_reg.wptr + AW'(1);
    end
    if (do_rd) begin
      st_next.rptr = (st_reg.rptr == AW'(DEPTH-1)) ? '0 : st_reg.rptr + AW'(1);
    end
    if (do_wr && !do_rd) begin
      st_next.cnt = st_reg.cnt + (AW+1)'(1);
    end else if (do_rd && !do_wr) begin
      st_next.cnt = st_reg.cnt - (AW+1)'(1);
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// --------------------------------------------------------------------
// Virtual channel assigner top
// --------------------------------------------------------------------
module vca_assigner #(
  parameter int NUM_LINKS  = 4,
  parameter int LINK_W     = 2,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                     clk_in,
  input  wire logic                     sys_rst_in,
  // Avalon-MM slave
  input  wire logic [7:0]               avs_address_in,
  input  wire logic                     avs_read_in,
  input  wire logic                     avs_write_in,
  input  wire logic [31:0]              avs_writedata_in,
  output logic [31:0]                   avs_readdata_out,
  output logic                          avs_waitrequest_out,
  // Frames to classify
  input  wire logic                     frm_valid_in,
  output logic                          frm_ready_out,
  input  wire logic [LINK_W-1:0]        frm_link_in,
  input  wire logic [vca_pkg::DID_W-1:0] frm_did_in,
  input  wire logic                     frm_ctrl_class_in,
  input  wire logic                     frm_bcast_in,
  // Classified frames
  output logic                          out_valid_out,
  input  wire logic                     out_ready_in,
  output logic [LINK_W-1:0]             out_link_out,
  output logic [vca_pkg::DID_W-1:0]     out_did_out,
  output logic [vca_pkg::VC_W-1:0]      out_vc_out,
  output logic                          out_urgent_out,
  output logic                          out_cfg_err_out,
  output logic [NUM_LINKS-1:0]          cfg_err_out
);
  localparam int ENT_W = LINK_W + vca_pkg::DID_W + vca_pkg::VC_W + 2;

  typedef struct packed {
    logic                                    ack;
    logic [31:0]                             rdata;
    logic [NUM_LINKS-1:0][vca_pkg::CFG_W-1:0] cfg;
    logic [NUM_LINKS-1:0]                    cfg_err;
    logic [31:0]                             frame_cnt;
    logic                                    stg_full;
    logic                                    stg_urgent;
    logic [ENT_W-1:0]                        stg_ent;
    logic                                    out_valid;
    logic                                    out_urgent;
    logic [ENT_W-1:0]                        out_ent;
  } vca_state_type;

  vca_state_type     st_reg;
  vca_state_type     st_next;
  logic              norm_wr_ready;
  logic              prio_wr_ready;
  logic              norm_rd_valid;
  logic              prio_rd_valid;
  logic              norm_rd_ready;
  logic              prio_rd_ready;
  logic [ENT_W-1:0]  norm_rd_data;
  logic [ENT_W-1:0]  prio_rd_data;
  logic              stg_push;
  logic              out_load;

  // ------------------------------------------------------------------
  // Field width of the destination slice for a scheme and count
  // ------------------------------------------------------------------
  function automatic logic [3:0] field_width(input logic [1:0] scheme,
                                             input logic [8:0] count);
    logic [3:0] w;
    w = vca_pkg::FW_NONE;
    if (scheme == vca_pkg::VCA_SCHEME_FIXED) begin
      // Only eight or more channels are listed here
      unique case (count)
        vca_pkg::FIX_N0: w = vca_pkg::FW_2;
        vca_pkg::FIX_N1: w = vca_pkg::FW_3;
        vca_pkg::FIX_N2: w = vca_pkg::FW_4;
        vca_pkg::FIX_N3: w = vca_pkg::FW_5;
        vca_pkg::FIX_N4: w = vca_pkg::FW_6;
        vca_pkg::FIX_N5: w = vca_pkg::FW_7;
        default:         w = vca_pkg::FW_NONE;
      endcase
    end else if (scheme == vca_pkg::VCA_SCHEME_VARIABLE) begin
      unique case (count)
        vca_pkg::VAR_N0: w = vca_pkg::FW_2;
        vca_pkg::VAR_N1: w = vca_pkg::FW_3;
        vca_pkg::VAR_N2: w = vca_pkg::FW_4;
        vca_pkg::VAR_N3: w = vca_pkg::FW_5;
        vca_pkg::VAR_N4: w = vca_pkg::FW_6;
        vca_pkg::VAR_N5: w = vca_pkg::FW_7;
        vca_pkg::VAR_N6: w = vca_pkg::FW_8;
        default:         w = vca_pkg::FW_NONE;
      endcase
    end
    return w;
  endfunction

  // ------------------------------------------------------------------
  // Configuration check: simple takes two channels only
  // ------------------------------------------------------------------
  function automatic logic cfg_bad(input logic [vca_pkg::CFG_W-1:0] cfg);
    logic [1:0] scheme;
    logic [8:0] count;
    logic       bad;
    scheme = cfg[vca_pkg::SCHEME_W-1:0];
    count  = cfg[vca_pkg::CFG_W-1:vca_pkg::SCHEME_W];
    if (scheme == vca_pkg::VCA_SCHEME_SIMPLE) begin
      bad = (count != vca_pkg::CNT_SIMPLE);
    end else begin
      bad = (field_width(scheme, count) == vca_pkg::FW_NONE);
    end
    return bad;
  endfunction

  // ------------------------------------------------------------------
  // Channel choice for one frame, returns {error, urgent, channel}
  // ------------------------------------------------------------------
  function automatic logic [9:0] pick_vc(input logic [vca_pkg::CFG_W-1:0] cfg,
                                         input logic [23:0] did,
                                         input logic        ctrl,
                                         input logic        bcast);
    logic [1:0] scheme;
    logic [8:0] count;
    logic [3:0] w;
    logic [7:0] mask;
    logic [7:0] field;
    logic [7:0] vc;
    logic       err;
    logic       urgent;
    scheme = cfg[vca_pkg::SCHEME_W-1:0];
    count  = cfg[vca_pkg::CFG_W-1:vca_pkg::SCHEME_W];
    w      = field_width(scheme, count);
    mask   = vca_pkg::VC_FULL >> (4'h8 - w);
    field  = did[vca_pkg::DID_FIELD +: 8] & mask;
    err    = cfg_bad(cfg);
    urgent = 1'b0;
    vc     = vca_pkg::VC_CTRL;
    if (err) begin
      vc = vca_pkg::VC_CTRL;
    end else begin
      unique case (scheme)
        vca_pkg::VCA_SCHEME_SIMPLE: begin
          vc = ctrl ? vca_pkg::VC_CTRL : vca_pkg::VC_DATA;
        end
        vca_pkg::VCA_SCHEME_FIXED: begin
          if (ctrl) begin
            vc = vca_pkg::VC_CTRL;
          end else if (bcast) begin
            vc = 8'(count - vca_pkg::CNT_ONE);
          end else begin
            // Field max is count minus five, so 1 and n-2 stay unused
            vc = vca_pkg::VC_FIX_LOW + field;
          end
        end
        vca_pkg::VCA_SCHEME_VARIABLE: begin
          vc     = field;
          urgent = ctrl || bcast;
        end
        default: begin
          vc = vca_pkg::VC_CTRL;
        end
      endcase
    end
    return {err, urgent, vc};
  endfunction

  // ------------------------------------------------------------------
  // Priority and normal queues
  // ------------------------------------------------------------------
  vca_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_norm_fifo (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .wr_valid_in  (st_reg.stg_full && !st_reg.stg_urgent),
    .wr_ready_out (norm_wr_ready),
    .wr_data_in   (st_reg.stg_ent),
    .rd_valid_out (norm_rd_valid),
    .rd_ready_in  (norm_rd_ready),
    .rd_data_out  (norm_rd_data)
  );

  vca_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_prio_fifo (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .wr_valid_in  (st_reg.stg_full && st_reg.stg_urgent),
    .wr_ready_out (prio_wr_ready),
    .wr_data_in   (st_reg.stg_ent),
    .rd_valid_out (prio_rd_valid),
    .rd_ready_in  (prio_rd_ready),
    .rd_data_out  (prio_rd_data)
  );

  // Stage drains into its queue; output slot prefers the urgent queue
  assign stg_push      = st_reg.stg_full &&
                         (st_reg.stg_urgent ? prio_wr_ready : norm_wr_ready);
  assign out_load      = !st_reg.out_valid || out_ready_in;
  assign prio_rd_ready = out_load;
  assign norm_rd_ready = out_load && !prio_rd_valid;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic [9:0]                   pick;
    logic [vca_pkg::CFG_W-1:0]    sel_cfg;
    logic [7:0]                   idx;
    logic                         in_link;
    st_next = st_reg;
    pick    = '0;
    sel_cfg = st_reg.cfg[frm_link_in];
    idx     = (avs_address_in - vca_pkg::ADDR_LINK_BASE) >> vca_pkg::LINK_STRIDE_LG;
    in_link = (avs_address_in >= vca_pkg::ADDR_LINK_BASE) &&
              (idx < 8'(NUM_LINKS)) && (avs_address_in[1:0] == 2'b00);

    // Bus: one wait cycle, answer held while waitrequest is low
    st_next.ack = (avs_read_in || avs_write_in) && !st_reg.ack;
    if (avs_read_in && !st_reg.ack) begin
      st_next.rdata = '0;
      if (avs_address_in == vca_pkg::ADDR_ID) begin
        st_next.rdata = vca_pkg::BLOCK_ID;
      end else if (avs_address_in == vca_pkg::ADDR_STATUS) begin
        st_next.rdata[NUM_LINKS-1:0] = st_reg.cfg_err;
      end else if (avs_address_in == vca_pkg::ADDR_FRAME_CNT) begin
        st_next.rdata = st_reg.frame_cnt;
      end else if (in_link) begin
        st_next.rdata[vca_pkg::SCHEME_LSB +: vca_pkg::SCHEME_W] =
          st_reg.cfg[idx[LINK_W-1:0]][vca_pkg::SCHEME_W-1:0];
        st_next.rdata[vca_pkg::COUNT_LSB +: vca_pkg::COUNT_W] =
          st_reg.cfg[idx[LINK_W-1:0]][vca_pkg::CFG_W-1:vca_pkg::SCHEME_W];
      end
    end
    // Write lands on the edge where waitrequest is seen low
    if (avs_write_in && st_reg.ack && in_link) begin
      st_next.cfg[idx[LINK_W-1:0]] = {
        avs_writedata_in[vca_pkg::COUNT_LSB +: vca_pkg::COUNT_W],
        avs_writedata_in[vca_pkg::SCHEME_LSB +: vca_pkg::SCHEME_W]};
    end
    // Error flags track the stored configuration
    for (int i = 0; i < NUM_LINKS; i++) begin
      st_next.cfg_err[i] = cfg_bad(st_next.cfg[i]);
    end

    // Input stage: one entry; ready is a flop, so rate is one per two cycles
    if (stg_push) begin
      st_next.stg_full = 1'b0;
    end
    if (frm_valid_in && !st_reg.stg_full) begin
      pick = pick_vc(sel_cfg, frm_did_in, frm_ctrl_class_in, frm_bcast_in);
      st_next.stg_full   = 1'b1;
      st_next.stg_urgent = pick[8];
      st_next.stg_ent    = {frm_link_in, frm_did_in, pick[7:0], pick[8], pick[9]};
      st_next.frame_cnt  = st_reg.frame_cnt + 32'h0000_0001;
    end

    // Output slot
    if (out_load) begin
      st_next.out_valid = prio_rd_valid || norm_rd_valid;
      if (prio_rd_valid) begin
        st_next.out_ent    = prio_rd_data;
        st_next.out_urgent = 1'b1;
      end else if (norm_rd_valid) begin
        st_next.out_ent    = norm_rd_data;
        st_next.out_urgent = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_reg       <= '0;
      for (int i = 0; i < NUM_LINKS; i++) begin
        st_reg.cfg[i] <= {vca_pkg::CFG_RST_COUNT, vca_pkg::CFG_RST_SCHEME};
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all from the state register
  // ------------------------------------------------------------------
  assign avs_readdata_out    = st_reg.rdata;
  assign avs_waitrequest_out = !st_reg.ack;
  assign frm_ready_out       = !st_reg.stg_full;
  assign out_valid_out       = st_reg.out_valid;
  assign out_link_out        = st_reg.out_ent[ENT_W-1 -: LINK_W];
  assign out_did_out         = st_reg.out_ent[ENT_W-LINK_W-1 -: vca_pkg::DID_W];
  assign out_vc_out          = st_reg.out_ent[2 +: vca_pkg::VC_W];
  assign out_urgent_out      = st_reg.out_urgent;
  assign out_cfg_err_out     = st_reg.out_ent[0];
  assign cfg_err_out         = st_reg.cfg_err;
endmodule

// ---- dv/vca_assigner_monitor.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module vca_assigner_monitor (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        frm_valid_in,
  input wire logic        frm_ready_out,
  input wire logic        out_valid_out,
  input wire logic        out_ready_in,
  input wire logic [23:0] out_did_out,
  input wire logic [7:0]  out_vc_out,
  input wire logic        out_cfg_err_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // Any bus request, either direction
  logic req;
  assign req = avs_read_in || avs_write_in;

  a_bus_one_wait: assert property (
    req && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("bus answer late");
  a_ack_one_cycle: assert property (
    !avs_waitrequest_out |=> avs_waitrequest_out) else $error("bus answer too long");
  a_ack_has_cause: assert property (
    $fell(avs_waitrequest_out) |-> $past(req)) else $error("bus answer without request");
  a_unmapped_zero: assert property (
    avs_read_in && !avs_waitrequest_out && (avs_address_in == 8'h0c || avs_address_in >= 8'h20)
    |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  a_id_word: assert property (
    avs_read_in && !avs_waitrequest_out && avs_address_in == 8'h00
    |-> avs_readdata_out == vca_pkg::BLOCK_ID) else $error("identity word wrong");
  a_take_drop: assert property (
    frm_valid_in && frm_ready_out |=> !frm_ready_out) else $error("ready held after take");
  a_drop_cause: assert property (
    $fell(frm_ready_out) |-> $past(frm_valid_in)) else $error("ready dropped without frame");
  a_out_hold: assert property (
    out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_vc_out)
    && $stable(out_did_out)) else $error("output changed before taken");
  a_frame_latency: assert property (
    frm_valid_in && frm_ready_out && !out_valid_out |-> ##[1:3] out_valid_out)
    else $error("classified frame late");
  a_err_vc_zero: assert property (
    out_valid_out && out_cfg_err_out |-> out_vc_out == 8'h00) else $error("bad config vc");

  // Main scenarios reached
  c_take: cover property (frm_valid_in && frm_ready_out);
  c_stall: cover property (out_valid_out && !out_ready_in);
  c_cfg_err: cover property (out_valid_out && out_cfg_err_out);
endmodule

bind vca_assigner vca_assigner_monitor u_mon (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .frm_valid_in(frm_valid_in), .frm_ready_out(frm_ready_out),
  .out_valid_out(out_valid_out), .out_ready_in(out_ready_in), .out_did_out(out_did_out),
  .out_vc_out(out_vc_out), .out_cfg_err_out(out_cfg_err_out));

// ---- dv/vca_link_sink.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Neighbouring port: takes classified frames, may stall
// ------------------------------------------------------------
module vca_link_sink (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        hold_in,
  input  wire logic        valid_in,
  output logic             ready_out = 1'b0,
  input  wire logic [35:0] word_in
);
  logic [35:0] got [$];

  // Ready follows hold one edge late, like a registered credit check
  always @(posedge clk_in) begin
    ready_out <= !hold_in && !sys_rst_in;
    if (valid_in && ready_out) got.push_back(word_in);
  end
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Assigner bench
// ------------------------------------------------------------
module tb;
  typedef struct packed {
    logic [1:0]  sch;
    logic [8:0]  cnt;
    logic [1:0]  lnk;
    logic [23:0] did;
    logic        ctl;
    logic        bc;
    logic [7:0]  vc;
    logic        urg;
    logic        err;
  } vca_row_type;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic        fv = 1'b0;
  logic [1:0]  fl = 2'h0;
  logic [23:0] fd = 24'h0;
  logic        fc = 1'b0;
  logic        fb = 1'b0;
  logic        hold = 1'b0;
  logic [31:0] rdat, q;
  logic        wreq, frdy, ov, ordy, ourg, oerr, ok;
  logic [1:0]  olnk, wl;
  logic [23:0] odid;
  logic [7:0]  ovc, kb;
  logic [3:0]  cerr;
  logic [33:0] w;
  int          miscompares = 0;
  int          n_compared = 0;
  int          acc;
  // Link config, frame, then expected vc, urgent, error
  vca_row_type rows [15] = '{
    '{2'h0,9'h002,2'h0,24'h000300,1'b1,1'b0,8'h00,1'b0,1'b0},
    '{2'h0,9'h002,2'h0,24'h000300,1'b0,1'b1,8'h01,1'b0,1'b0},
    '{2'h1,9'h008,2'h1,24'h000300,1'b1,1'b1,8'h00,1'b0,1'b0},
    '{2'h1,9'h008,2'h1,24'h000100,1'b0,1'b1,8'h07,1'b0,1'b0},
    '{2'h1,9'h008,2'h1,24'h000300,1'b0,1'b0,8'h05,1'b0,1'b0},
    '{2'h1,9'h008,2'h1,24'h000000,1'b0,1'b0,8'h02,1'b0,1'b0},
    '{2'h1,9'h00c,2'h2,24'h000700,1'b0,1'b0,8'h09,1'b0,1'b0},
    '{2'h1,9'h084,2'h2,24'h00ff00,1'b0,1'b0,8'h81,1'b0,1'b0},
    '{2'h2,9'h004,2'h3,24'h000200,1'b1,1'b0,8'h02,1'b1,1'b0},
    '{2'h2,9'h008,2'h3,24'h000700,1'b0,1'b0,8'h07,1'b0,1'b0},
    '{2'h2,9'h100,2'h3,24'h00ff00,1'b0,1'b1,8'hff,1'b1,1'b0},
    '{2'h2,9'h004,2'h3,24'h00ff00,1'b0,1'b0,8'h03,1'b0,1'b0},
    '{2'h1,9'h004,2'h2,24'h000300,1'b0,1'b0,8'h00,1'b0,1'b1},
    '{2'h2,9'h00c,2'h2,24'h000300,1'b0,1'b0,8'h00,1'b0,1'b1},
    '{2'h3,9'h008,2'h2,24'h000300,1'b0,1'b1,8'h00,1'b0,1'b1}};

  initial forever #20 clk_in = ~clk_in;

  vca_assigner dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .frm_valid_in(fv), .frm_ready_out(frdy), .frm_link_in(fl),
    .frm_did_in(fd), .frm_ctrl_class_in(fc), .frm_bcast_in(fb), .out_valid_out(ov),
    .out_ready_in(ordy), .out_link_out(olnk), .out_did_out(odid), .out_vc_out(ovc),
    .out_urgent_out(ourg), .out_cfg_err_out(oerr), .cfg_err_out(cerr));
  vca_link_sink sink (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hold_in(hold),
    .valid_in(ov), .ready_out(ordy), .word_in({olnk, oerr, ourg, ovc, odid}));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Avalon access; data taken and request dropped at the edge seeing waitrequest low
  task automatic bus(input logic wen, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    adr <= a; wdat <= d; wr <= wen; rd <= !wen;
    do @(posedge clk_in); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  // Offer one frame; gives up after 30 cycles so refusal can be seen
  task automatic send(input logic [1:0] l, input logic [23:0] d, input logic c, input logic b);
    int k;
    @(posedge clk_in);
    fv <= 1'b1; fl <= l; fd <= d; fc <= c; fb <= b;
    k = 0;
    do begin @(posedge clk_in); k++; end while (frdy !== 1'b1 && k < 30);
    ok = (frdy === 1'b1);
    fv <= 1'b0;
  endtask
  task automatic grab();
    int k;
    k = 0;
    while (sink.got.size() == 0 && k < 40) begin @(negedge clk_in); k++; end
    if (sink.got.size() == 0) chk(34'h0, 34'h1);
    else {wl, w} = sink.got.pop_front();
  endtask
  task automatic summarize();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_in);
    chk({30'h0, cerr}, 34'h0);
    chk({32'h0, ov, frdy}, 34'h1);
    bus(1'b0, 8'h10, 32'h0); chk(34'(q), 34'h0002_0000);
    bus(1'b0, 8'h00, 32'h0); chk(34'(q), 34'(vca_pkg::BLOCK_ID));
    bus(1'b1, 8'h0c, 32'hffff_ffff); bus(1'b0, 8'h0c, 32'h0); chk(34'(q), 34'h0);
    foreach (rows[i]) begin
      bus(1'b1, 8'h10 + {4'h0, rows[i].lnk, 2'h0}, {7'h00, rows[i].cnt, 14'h0, rows[i].sch});
      send(rows[i].lnk, rows[i].did, rows[i].ctl, rows[i].bc);
      grab(); chk(w, {rows[i].err, rows[i].urg, rows[i].vc, rows[i].did});
      chk(34'(wl), 34'(rows[i].lnk));
    end
    chk({30'h0, cerr}, 34'h4);
    bus(1'b0, 8'h04, 32'h0); chk(34'(q), 34'h4);
    bus(1'b0, 8'h14, 32'h0); chk(34'(q), 34'h0008_0001);
    // Same frame, two links, two schemes
    send(2'h0, 24'h000300, 1'b0, 1'b0); send(2'h1, 24'h000300, 1'b0, 1'b0);
    grab(); chk(w, {2'h0, 8'h01, 24'h000300});
    grab(); chk(w, {2'h0, 8'h05, 24'h000300});
    chk(34'(wl), 34'h1);
    // Control frame overtakes a queued plain frame
    @(posedge clk_in) hold <= 1'b1;
    send(2'h3, 24'h000100, 1'b0, 1'b0); send(2'h3, 24'h000200, 1'b0, 1'b0);
    send(2'h3, 24'h000300, 1'b1, 1'b0);
    @(posedge clk_in) hold <= 1'b0;
    grab(); chk(w, {2'h0, 8'h01, 24'h000100});
    grab(); chk(w, {2'h1, 8'h03, 24'h000300});
    grab(); chk(w, {2'h0, 8'h02, 24'h000200});
    // Fill while stalled until refused: slot, 8-deep queue, stage
    @(posedge clk_in) hold <= 1'b1;
    acc = 0;
    for (int k = 0; k < 12; k++) begin
      kb = 8'(k);
      send(2'h3, {8'h00, kb, 8'h00}, 1'b0, 1'b0);
      if (ok) acc++;
    end
    chk(34'(acc), 34'd10);
    @(posedge clk_in) hold <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      kb = 8'(k);
      grab(); chk(w, {2'h0, 6'h00, kb[1:0], 8'h00, kb, 8'h00});
    end
    bus(1'b0, 8'h08, 32'h0); chk(34'(q), 34'd30);
    // Reset in mid-run brings back the default link setup and clears the count
    @(posedge clk_in) sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    bus(1'b0, 8'h14, 32'h0); chk(34'(q), 34'h0002_0000);
    bus(1'b0, 8'h08, 32'h0); chk(34'(q), 34'h0);
    chk({30'h0, cerr}, 34'h0);
    chk({32'h0, ov, frdy}, 34'h1);
    summarize();
  end

  // Tests need under 2000 cycles; this limit only catches a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    summarize();
  end
endmodule
